// ---- hdl/phmp_pkg.sv ----
// Package with register map, control bit positions and shared types of the parallel host message port.
package phmp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_LVL_W = 6;
  localparam logic [FIFO_LVL_W-1:0] FIFO_THRESHOLD_DEFAULT = 6'h1C;
  localparam logic [ADDR_W-1:0] ADDR_MESSAGE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_PCM = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_COMPRESSED = 2'h3;
  localparam int BIT_RESERVED_HI = 7;
  localparam int BIT_CMP_HOLD = 6;
  localparam int BIT_PCM_HOLD = 5;
  localparam int BIT_PCM_NEARLY_FULL = 4;
  localparam int BIT_CMP_NEARLY_FULL = 3;
  localparam int BIT_INBOUND_BUSY = 2;
  localparam int BIT_OUTBOUND_VALID = 1;
  localparam int BIT_RESERVED_LO = 0;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] SYNC_ZERO = 3'h0;
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  // Host bus pins after the pin synchronisers.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rw_sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } phmp_bus_s;

  // One byte headed for an input buffer.
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } phmp_byte_s;

  typedef enum logic [1:0] {
    PHMP_IDLE,
    PHMP_READ,
    PHMP_WRITE
  } phmp_cycle_e;
endpackage

// ---- hdl/phmp_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides and a fill level output.
`timescale 1ns/1ps
module phmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int LVL_W = 6
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [LVL_W-1:0] level_q, level_d;
  logic push, pop;

  // Handshakes are honest: full blocks the writer, empty hides stale data.
  assign in_ready = (level_q != LVL_FULL) && !flush;
  assign out_valid = (level_q != '0) && !flush;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q];
  assign level = level_q;

  // Pointer and level arithmetic; flush empties the buffer in one cycle.
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    level_d = level_q;
    if (flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      level_d = '0;
    end else begin
      if (push) begin
        wr_ptr_d = wr_ptr_q + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_d = rd_ptr_q + PTR_ONE;
      end
      if (push && !pop) begin
        level_d = level_q + LVL_ONE;
      end else if (pop && !push) begin
        level_d = level_q - LVL_ONE;
      end
    end
  end

  // Storage array has no reset, so it maps onto plain memory.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // State registers.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      level_q <= level_d;
    end
  end
endmodule

// ---- hdl/phmp_top.sv ----
// Parallel host message port: host bus slave, message handshake, control bits and two audio input buffers.
//
// Operation
// - Address pins pick one of four registers.
// - Separate inbound and outbound message bytes.
// - Host write sets busy; core read clears.
// - Core load sets ready; host read clears.
// - Control bit 6 holds compressed port reset.
// - Control bit 5 holds PCM port reset.
// - Bit 4 shows PCM buffer nearly full.
// - Bit 3 shows compressed buffer nearly full.
// - PCM port bytes enter PCM buffer.
// - Compressed port bytes enter compressed buffer.
// - Only message and control registers are readable.
// - Interrupt follows outbound ready when enabled.
// - Interrupt also announces unsolicited core messages.
// - Split strobe read: device drives register.
// - Direction high plus data strobe reads.
// - Nearly full sets at threshold level.
`timescale 1ns/1ps
module phmp_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic strobe_mode,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_strobe_n,
  input wire logic rw_sel,
  input wire logic addr_select_high,
  input wire logic addr_select_low,
  input wire logic [phmp_pkg::DATA_W-1:0] data_in,
  output logic [phmp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic message_pending_irq_n,
  input wire logic notify_enable,
  input wire logic unsolicited_pending,
  input wire logic [phmp_pkg::FIFO_LVL_W-1:0] buffer_threshold,
  input wire logic core_msg_load,
  input wire logic [phmp_pkg::DATA_W-1:0] core_msg_data,
  input wire logic core_msg_take,
  output logic [phmp_pkg::DATA_W-1:0] core_msg_in,
  output logic inbound_busy_flag,
  output logic outbound_valid_flag,
  output logic pcm_port_hold,
  output logic compressed_port_hold,
  output logic pcm_valid,
  input wire logic pcm_ready,
  output logic [phmp_pkg::DATA_W-1:0] pcm_data,
  output logic cmp_valid,
  input wire logic cmp_ready,
  output logic [phmp_pkg::DATA_W-1:0] cmp_data,
  output logic pcm_buffer_nearly_full,
  output logic compressed_buffer_nearly_full,
  output logic pcm_in_ready,
  output logic cmp_in_ready
);
  localparam int SYNC_W = 5 + phmp_pkg::ADDR_W + phmp_pkg::DATA_W;

  // Three-stage synchronisers on every host pin; a level is taken once stages two and three agree.
  logic [SYNC_W-1:0] raw_pins;
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, stable_q, stable_d;
  logic [SYNC_W-1:0] s1_d, s2_d, s3_d;
  phmp_pkg::phmp_bus_s bus;
  logic strobe_mode_s;

  // In data strobe mode the single strobe stands for both; direction picks read or write.
  assign raw_pins = {strobe_mode, cs_n,
                     strobe_mode ? ~(data_strobe_n == 1'b0 && rw_sel) : rd_n,
                     strobe_mode ? ~(data_strobe_n == 1'b0 && !rw_sel) : wr_n,
                     rw_sel, addr_select_high, addr_select_low, data_in};

  // Pipeline next values; the agree test only reads stages two and three.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_comb begin
        s1_d[gi] = raw_pins[gi];
        s2_d[gi] = s1_q[gi];
        s3_d[gi] = s2_q[gi];
        stable_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : stable_q[gi];
      end
    end
  endgenerate

  localparam logic [SYNC_W-1:0] SYNC_RESET = {1'b0, phmp_pkg::SYNC_IDLE, {(SYNC_W - 4){1'b0}}};

  // Idle reset value keeps strobes and chip select released, so no false cycle opens after reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
      stable_q <= SYNC_RESET;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      stable_q <= stable_d;
    end
  end

  assign strobe_mode_s = stable_q[SYNC_W-1];
  assign bus = stable_q[SYNC_W-2:0];

  // Cycle tracker: a write is taken on the edge that closes it, so data has settled by then.
  phmp_pkg::phmp_cycle_e cyc_q, cyc_d;
  logic [phmp_pkg::ADDR_W-1:0] cyc_addr_q, cyc_addr_d;
  logic [phmp_pkg::DATA_W-1:0] cyc_data_q, cyc_data_d;
  logic wr_done, rd_done, rd_active;
  logic cs_on, rd_on, wr_on;

  assign cs_on = !bus.cs_n;
  assign rd_on = cs_on && !bus.rd_n;
  assign wr_on = cs_on && !bus.wr_n;

  always_comb begin
    cyc_d = cyc_q;
    cyc_addr_d = cyc_addr_q;
    cyc_data_d = cyc_data_q;
    wr_done = 1'b0;
    rd_done = 1'b0;
    case (cyc_q)
      phmp_pkg::PHMP_IDLE: begin
        if (wr_on) begin
          cyc_d = phmp_pkg::PHMP_WRITE;
          cyc_addr_d = bus.addr;
          cyc_data_d = bus.data;
        end else if (rd_on) begin
          cyc_d = phmp_pkg::PHMP_READ;
          cyc_addr_d = bus.addr;
        end
      end
      phmp_pkg::PHMP_WRITE: begin
        if (wr_on) begin
          cyc_data_d = bus.data;
        end else begin
          wr_done = 1'b1;
          cyc_d = phmp_pkg::PHMP_IDLE;
        end
      end
      phmp_pkg::PHMP_READ: begin
        if (!rd_on) begin
          rd_done = 1'b1;
          cyc_d = phmp_pkg::PHMP_IDLE;
        end
      end
      default: begin
        cyc_d = phmp_pkg::PHMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= phmp_pkg::PHMP_IDLE;
      cyc_addr_q <= phmp_pkg::ADDR_MESSAGE;
      cyc_data_q <= phmp_pkg::BYTE_ZERO;
    end else begin
      cyc_q <= cyc_d;
      cyc_addr_q <= cyc_addr_d;
      cyc_data_q <= cyc_data_d;
    end
  end
  assign rd_active = (cyc_q == phmp_pkg::PHMP_READ);

  // Message and control registers; set beats clear on every handshake flag.
  logic [phmp_pkg::DATA_W-1:0] msg_in_q, msg_in_d, msg_out_q, msg_out_d;
  logic busy_q, busy_d, ready_q, ready_d, pcm_hold_q, pcm_hold_d, cmp_hold_q, cmp_hold_d;
  logic wr_msg, wr_ctl, wr_pcm, wr_cmp, rd_msg;

  assign wr_msg = wr_done && (cyc_addr_q == phmp_pkg::ADDR_MESSAGE);
  assign wr_ctl = wr_done && (cyc_addr_q == phmp_pkg::ADDR_CONTROL);
  assign wr_pcm = wr_done && (cyc_addr_q == phmp_pkg::ADDR_PCM);
  assign wr_cmp = wr_done && (cyc_addr_q == phmp_pkg::ADDR_COMPRESSED);
  assign rd_msg = rd_done && (cyc_addr_q == phmp_pkg::ADDR_MESSAGE);

  always_comb begin
    msg_in_d = msg_in_q;
    msg_out_d = msg_out_q;
    busy_d = busy_q;
    ready_d = ready_q;
    pcm_hold_d = pcm_hold_q;
    cmp_hold_d = cmp_hold_q;
    if (core_msg_take) begin
      busy_d = 1'b0;
    end
    if (wr_msg) begin
      msg_in_d = cyc_data_q;
      busy_d = 1'b1;
    end
    if (rd_msg) begin
      ready_d = 1'b0;
    end
    if (core_msg_load) begin
      msg_out_d = core_msg_data;
      ready_d = 1'b1;
    end
    // Reserved bits 7 and 0 are not stored, so a stray one there does no harm.
    if (wr_ctl) begin
      cmp_hold_d = cyc_data_q[phmp_pkg::BIT_CMP_HOLD];
      pcm_hold_d = cyc_data_q[phmp_pkg::BIT_PCM_HOLD];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msg_in_q <= phmp_pkg::BYTE_ZERO;
      msg_out_q <= phmp_pkg::BYTE_ZERO;
      busy_q <= 1'b0;
      ready_q <= 1'b0;
      pcm_hold_q <= 1'b0;
      cmp_hold_q <= 1'b0;
    end else begin
      msg_in_q <= msg_in_d;
      msg_out_q <= msg_out_d;
      busy_q <= busy_d;
      ready_q <= ready_d;
      pcm_hold_q <= pcm_hold_d;
      cmp_hold_q <= cmp_hold_d;
    end
  end

  // Input buffers; a hold bit flushes its buffer and keeps it shut.
  logic [phmp_pkg::FIFO_LVL_W-1:0] pcm_level, cmp_level;

  phmp_fifo #(
    .WIDTH(phmp_pkg::DATA_W),
    .DEPTH(phmp_pkg::FIFO_DEPTH),
    .LVL_W(phmp_pkg::FIFO_LVL_W)
  ) u_pcm_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(pcm_hold_q),
    .in_valid(wr_pcm),
    .in_ready(pcm_in_ready),
    .in_data(cyc_data_q),
    .out_valid(pcm_valid),
    .out_ready(pcm_ready),
    .out_data(pcm_data),
    .level(pcm_level)
  );

  phmp_fifo #(
    .WIDTH(phmp_pkg::DATA_W),
    .DEPTH(phmp_pkg::FIFO_DEPTH),
    .LVL_W(phmp_pkg::FIFO_LVL_W)
  ) u_cmp_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(cmp_hold_q),
    .in_valid(wr_cmp),
    .in_ready(cmp_in_ready),
    .in_data(cyc_data_q),
    .out_valid(cmp_valid),
    .out_ready(cmp_ready),
    .out_data(cmp_data),
    .level(cmp_level)
  );

  // Nearly full is a level compare, so it drops again as the core drains the buffer.
  assign pcm_buffer_nearly_full = (pcm_level >= buffer_threshold);
  assign compressed_buffer_nearly_full = (cmp_level >= buffer_threshold);

  // Read data: the message register is sampled as the read opens and held until the strobe rises; the control byte follows live status.
  logic [phmp_pkg::DATA_W-1:0] status_byte, rdata_q, rdata_d;
  logic oe_q, oe_d, irq_n_q, irq_n_d;

  always_comb begin
    status_byte = phmp_pkg::BYTE_ZERO;
    status_byte[phmp_pkg::BIT_PCM_NEARLY_FULL] = pcm_buffer_nearly_full;
    status_byte[phmp_pkg::BIT_CMP_NEARLY_FULL] = compressed_buffer_nearly_full;
    status_byte[phmp_pkg::BIT_INBOUND_BUSY] = busy_q;
    status_byte[phmp_pkg::BIT_OUTBOUND_VALID] = ready_q;
  end

  always_comb begin
    rdata_d = rdata_q;
    oe_d = 1'b0;
    if (cyc_d == phmp_pkg::PHMP_READ) begin
      // Audio ports are write-only; a stray read there sees zero and the bus stays released.
      oe_d = (cyc_addr_d == phmp_pkg::ADDR_MESSAGE) || (cyc_addr_d == phmp_pkg::ADDR_CONTROL);
      if (!rd_active) begin
        rdata_d = (cyc_addr_d == phmp_pkg::ADDR_MESSAGE) ? msg_out_q :
                  (cyc_addr_d == phmp_pkg::ADDR_CONTROL) ? status_byte : phmp_pkg::BYTE_ZERO;
      end else if (cyc_addr_q == phmp_pkg::ADDR_CONTROL) begin
        rdata_d = status_byte;
      end
    end
    irq_n_d = !(notify_enable && (ready_q || unsolicited_pending));
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= phmp_pkg::BYTE_ZERO;
      oe_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      oe_q <= oe_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign data_out = rdata_q;
  assign data_oe = oe_q;
  assign message_pending_irq_n = irq_n_q;
  assign core_msg_in = msg_in_q;
  assign inbound_busy_flag = busy_q;
  assign outbound_valid_flag = ready_q;
  assign pcm_port_hold = pcm_hold_q;
  assign compressed_port_hold = cmp_hold_q;
  logic unused_mode;
  assign unused_mode = strobe_mode_s ^ bus.rw_sel;
endmodule

// ---- verification/phmp_monitor.sv ----
// Checker of flags, read drive, interrupt and channel holds at the port pins.
`timescale 1ns/1ps
module phmp_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic strobe_mode,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic addr_select_high,
  input wire logic addr_select_low,
  input wire logic data_oe,
  input wire logic message_pending_irq_n,
  input wire logic notify_enable,
  input wire logic unsolicited_pending,
  input wire logic core_msg_load,
  input wire logic core_msg_take,
  input wire logic inbound_busy_flag,
  input wire logic outbound_valid_flag,
  input wire logic pcm_port_hold,
  input wire logic compressed_port_hold,
  input wire logic pcm_in_ready,
  input wire logic cmp_in_ready,
  input wire logic pcm_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // A split-strobe message write whose chip select has just risen.
  sequence msg_write_end;
    (!cs_n && !wr_n && !strobe_mode && !addr_select_high && !addr_select_low) ##1 cs_n;
  endsequence
  // The interrupt is a registered level, so only a cause that has stood a while is judged.
  sequence irq_cause;
    (notify_enable && (outbound_valid_flag || unsolicited_pending))[*3];
  endsequence
  busy_set_a: assert property (msg_write_end |-> ##[1:8] inbound_busy_flag) else $error("busy not set");
  busy_idle_a: assert property ($rose(inbound_busy_flag) |-> cs_n) else $error("busy set mid cycle");
  take_clear_a: assert property (core_msg_take && cs_n |=> !inbound_busy_flag) else $error("busy kept");
  ready_set_a: assert property (core_msg_load |=> outbound_valid_flag) else $error("ready not set");
  ready_clear_a: assert property ($fell(outbound_valid_flag) |-> !addr_select_high && !addr_select_low)
    else $error("ready cleared without message read");
  oe_addr_a: assert property (data_oe |-> !addr_select_high) else $error("audio port driven");
  oe_cause_a: assert property ($rose(data_oe) |-> !cs_n) else $error("drive without select");
  irq_on_a: assert property (irq_cause |-> !message_pending_irq_n) else $error("irq missing");
  irq_off_a: assert property ((!notify_enable)[*3] |-> message_pending_irq_n) else $error("irq unmasked");
  pcm_hold_a: assert property (pcm_port_hold[*3] |-> !pcm_valid && !pcm_in_ready) else $error("pcm hold");
  cmp_hold_a: assert property (compressed_port_hold[*2] |-> !cmp_in_ready) else $error("cmp hold");
endmodule
bind phmp_top phmp_monitor i_phmp_monitor (.*);

// ---- verification/phmp_host.sv ----
// Behavioural host controller that runs byte cycles in either strobe style.
`timescale 1ns/1ps
module phmp_host (
  input wire logic clock,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic strobe_mode,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic data_strobe_n,
  output logic rw_sel,
  output logic addr_select_high,
  output logic addr_select_low,
  output logic [7:0] data_in
);
  logic drv = 1'b0;
  logic [7:0] wdat = 8'h00;
  // An undriven bus shows the inverse byte, so a stale value never passes for an answer.
  assign data_in = data_oe ? data_out : (drv ? wdat : ~wdat);
  // Pins start idle with every strobe and the select high.
  initial begin
    {strobe_mode, cs_n, rd_n, wr_n, data_strobe_n, rw_sel, addr_select_high, addr_select_low} = 8'h7C;
  end
  // Strobes stay low eight cycles and high ten, longer than the synchronisers need.
  // Address stays put afterwards because the device releases the bus late.
  task automatic cycle(input logic m, input logic rd, input logic [1:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic oe);
    oe = 1'b0;
    @(posedge clock);
    strobe_mode <= m;
    @(posedge clock);
    {addr_select_high, addr_select_low} <= a;
    rw_sel <= rd;
    wdat <= d;
    drv <= !rd;
    cs_n <= 1'b0;
    if (m) data_strobe_n <= 1'b0;
    else if (rd) rd_n <= 1'b0;
    else wr_n <= 1'b0;
    repeat (8) begin
      @(posedge clock);
      oe = oe | data_oe;
      q = data_in;
    end
    {cs_n, rd_n, wr_n, data_strobe_n, drv} <= 5'h1E;
    repeat (10) @(posedge clock);
  endtask
endmodule

// ---- verification/phmp_top_test.sv ----
// Self-checking bench of the parallel host message port.
`timescale 1ns/1ps
module phmp_top_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic notify_enable = 1'b0;
  logic unsolicited_pending = 1'b0;
  logic core_msg_load = 1'b0;
  logic core_msg_take = 1'b0;
  logic pcm_ready = 1'b0;
  logic cmp_ready = 1'b0;
  logic mode = 1'b0;
  logic [5:0] buffer_threshold = 6'h04;
  logic [7:0] core_msg_data = 8'h00;
  logic strobe_mode, cs_n, rd_n, wr_n, data_strobe_n, rw_sel, addr_select_high, addr_select_low, oe;
  logic data_oe, message_pending_irq_n, inbound_busy_flag, outbound_valid_flag, pcm_port_hold, compressed_port_hold;
  logic pcm_valid, cmp_valid, pcm_buffer_nearly_full, compressed_buffer_nearly_full, pcm_in_ready, cmp_in_ready;
  logic [7:0] data_in, data_out, core_msg_in, pcm_data, cmp_data, q;
  int n_fail = 0;
  int checked = 0;
  phmp_top i_phmp_top (
    .clock(clock), .resetn(resetn), .strobe_mode(strobe_mode), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_strobe_n(data_strobe_n), .rw_sel(rw_sel), .addr_select_high(addr_select_high),
    .addr_select_low(addr_select_low), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .message_pending_irq_n(message_pending_irq_n), .notify_enable(notify_enable),
    .unsolicited_pending(unsolicited_pending), .buffer_threshold(buffer_threshold),
    .core_msg_load(core_msg_load), .core_msg_data(core_msg_data), .core_msg_take(core_msg_take),
    .core_msg_in(core_msg_in), .inbound_busy_flag(inbound_busy_flag), .outbound_valid_flag(outbound_valid_flag),
    .pcm_port_hold(pcm_port_hold), .compressed_port_hold(compressed_port_hold), .pcm_valid(pcm_valid),
    .pcm_ready(pcm_ready), .pcm_data(pcm_data), .cmp_valid(cmp_valid), .cmp_ready(cmp_ready),
    .cmp_data(cmp_data), .pcm_buffer_nearly_full(pcm_buffer_nearly_full),
    .compressed_buffer_nearly_full(compressed_buffer_nearly_full), .pcm_in_ready(pcm_in_ready),
    .cmp_in_ready(cmp_in_ready)
  );
  phmp_host i_phmp_host (
    .clock(clock), .data_out(data_out), .data_oe(data_oe), .strobe_mode(strobe_mode), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .data_strobe_n(data_strobe_n), .rw_sel(rw_sel),
    .addr_select_high(addr_select_high), .addr_select_low(addr_select_low), .data_in(data_in)
  );
  always #10 clock = ~clock;
  // Case inequality keeps an unknown from passing as a match.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic rd, input logic [1:0] a, input logic [7:0] d);
    i_phmp_host.cycle(mode, rd, a, d, q, oe);
  endtask
  // One core pulse: load an outbound byte or take the inbound one.
  task automatic core(input logic ld, input logic [7:0] d);
    @(posedge clock);
    core_msg_data <= d;
    core_msg_load <= ld;
    core_msg_take <= !ld;
    @(posedge clock);
    core_msg_load <= 1'b0;
    core_msg_take <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic bus_reset;
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (5) @(posedge clock);
    acc(1'b1, 2'h1, 8'h00);
    chk({oe, q & 8'h1E}, 16'h100);
    chk(message_pending_irq_n, 1'b1);
  endtask
  task automatic t_message(input logic m, input logic [7:0] hb, input logic [7:0] cb);
    // Let an edge pass so the enable is never driven twice in one time step.
    @(posedge clock);
    mode = m;
    notify_enable <= 1'b1;
    acc(1'b1, 2'h1, 8'h00);
    chk(q[2], 1'b0);
    acc(1'b0, 2'h0, hb);
    chk({inbound_busy_flag, message_pending_irq_n, core_msg_in}, {2'h3, hb});
    core(1'b1, cb);
    chk(message_pending_irq_n, 1'b0);
    acc(1'b1, 2'h1, 8'h00);
    chk(q & 8'h1E, 8'h06);
    acc(1'b1, 2'h0, 8'h00);
    chk({outbound_valid_flag, message_pending_irq_n, q}, {2'h1, cb});
    core(1'b0, 8'h00);
    chk(inbound_busy_flag, 1'b0);
    notify_enable <= 1'b0;
  endtask
  task automatic t_unsol;
    @(posedge clock);
    notify_enable <= 1'b1;
    unsolicited_pending <= 1'b1;
    repeat (4) @(posedge clock);
    chk(message_pending_irq_n, 1'b0);
    notify_enable <= 1'b0;
    repeat (4) @(posedge clock);
    chk(message_pending_irq_n, 1'b1);
    unsolicited_pending <= 1'b0;
  endtask
  // Fill one buffer past full with the drain stalled, then drain it in order.
  task automatic t_fifo(input logic [1:0] a);
    int i;
    for (i = 0; i < 33; i++) begin
      if (i == 3 || i == 4) chk(a[0] ? compressed_buffer_nearly_full : pcm_buffer_nearly_full, i == 4);
      acc(1'b0, a, i[7:0]);
    end
    chk(a[0] ? cmp_in_ready : pcm_in_ready, 1'b0);
    acc(1'b1, 2'h1, 8'h00);
    chk(q[4:3], a[0] ? 2'h1 : 2'h2);
    acc(1'b1, a, 8'h00);
    chk(oe, 1'b0);
    for (i = 0; i < 32; i++) begin
      @(posedge clock);
      chk({a[0] ? cmp_valid : pcm_valid, a[0] ? cmp_data : pcm_data}, {1'b1, i[7:0]});
      if (a[0]) cmp_ready <= 1'b1;
      else pcm_ready <= 1'b1;
      @(posedge clock);
      cmp_ready <= 1'b0;
      pcm_ready <= 1'b0;
    end
    @(posedge clock);
    chk(pcm_valid | cmp_valid, 1'b0);
  endtask
  // Holds flush and refuse; the reserved bits are set on purpose and must be ignored.
  task automatic t_hold;
    acc(1'b0, 2'h2, 8'h11);
    acc(1'b0, 2'h1, 8'h20);
    chk({pcm_port_hold, compressed_port_hold, pcm_valid, pcm_in_ready}, 16'h8);
    acc(1'b0, 2'h2, 8'h22);
    acc(1'b0, 2'h1, 8'hC1);
    chk({pcm_port_hold, compressed_port_hold, pcm_valid, cmp_in_ready}, 16'h4);
    acc(1'b0, 2'h1, 8'h00);
    acc(1'b0, 2'h2, 8'h33);
    chk({compressed_port_hold, cmp_in_ready, pcm_valid, pcm_data}, {3'h3, 8'h33});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // The whole run needs some two thousand cycles.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("MISMATCH at %0t: run did not finish", $time);
    complete_run();
  end
  initial begin
    bus_reset();
    t_message(1'b0, 8'hA5, 8'h3C);
    t_message(1'b1, 8'h5A, 8'hC3);
    t_unsol();
    t_fifo(2'h2);
    t_fifo(2'h3);
    t_hold();
    bus_reset();
    complete_run();
  end
endmodule
